/* rtl/fbm_consts.svh */
// offsets, field positions, reset values and timing counts of the fieldbus master state control
`ifndef FBM_CONSTS_SVH
`define FBM_CONSTS_SVH
// apb register byte offsets
`define FBM_OFS_CTRL 8'h00
`define FBM_OFS_STATE 8'h04
`define FBM_OFS_IRQ_STATUS 8'h08
`define FBM_OFS_IRQ_MASK 8'h0c
// control register fields
`define FBM_CTRL_CFG_LOADED 0
`define FBM_CTRL_SETUP_DONE 1
`define FBM_CTRL_GO_OP 2
`define FBM_CTRL_WIDTH 3
`define FBM_CTRL_RESET 3'h0
// state register fields
`define FBM_STATE_CODE_LSB 0
`define FBM_STATE_FLAGS_LSB 2
`define FBM_STATE_DIAG_DONE 5
// interrupt status and mask fields
`define FBM_IRQ_CFG_ERR 0
`define FBM_IRQ_HWADDR_ERR 1
`define FBM_IRQ_PORT_ERR 2
`define FBM_IRQ_STATE_CHG 3
`define FBM_IRQ_FALLBACK 4
`define FBM_IRQ_WIDTH 5
`define FBM_IRQ_RESET 5'h00
// two-bit control state codes
`define FBM_CODE_INIT 2'h0
`define FBM_CODE_PREOP 2'h1
`define FBM_CODE_SAFEOP 2'h2
`define FBM_CODE_OP 2'h3
// timing
`define FBM_CLK_MHZ 100
`define FBM_DIAG_CYCLES 4'h8
`define FBM_FLASH_HALF_MS 250
`define FBM_FLASH_HALF_CYCLES (`FBM_FLASH_HALF_MS * 1000 * `FBM_CLK_MHZ)
`endif

/* rtl/fbm_pkg.sv */
// types shared by the fieldbus master state control files
package fbm_pkg;
  // one-hot control states
  typedef enum logic [3:0] {
    ST_INIT = 4'h1,
    ST_PREOP = 4'h2,
    ST_SAFEOP = 4'h4,
    ST_OP = 4'h8
  } ctl_state_t;
  // power-on diagnosis results
  typedef struct packed {
    logic port_controller_fault_flag;
    logic hw_address_error_flag;
    logic net_config_error_flag;
  } diag_flags_t;
  // traffic permissions
  typedef struct packed {
    logic pd_out_en;
    logic pd_in_en;
    logic mailbox_en;
  } traffic_gate_t;
endpackage

/* rtl/run_indicator.sv */
// run indicator driver: dark, flashing or steady from the two-bit state code
`timescale 1ns/1ps
`include "fbm_consts.svh"
module run_indicator #(
  parameter int HALF_CYCLES = `FBM_FLASH_HALF_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // state code in
  input wire logic [1:0] state_code,
  // lamp out
  output logic run_led
);
  logic [31:0] blink_cnt_ff; // half-period counter
  logic [31:0] nxt_blink_cnt;
  logic blink_ff; // free-running flash phase
  logic nxt_blink;
  logic run_led_ff;
  logic nxt_run_led;

  // flash phase and lamp level
  always_comb begin
    nxt_blink_cnt = blink_cnt_ff + 32'h1;
    nxt_blink = blink_ff;
    if (blink_cnt_ff >= 32'(HALF_CYCLES - 1)) begin
      nxt_blink_cnt = 32'h0;
      nxt_blink = ~blink_ff;
    end
    // lamp follows the code only, registered one cycle behind it
    if (state_code == `FBM_CODE_INIT) begin
      nxt_run_led = 1'b0;
    end else if (state_code == `FBM_CODE_OP) begin
      nxt_run_led = 1'b1;
    end else begin
      nxt_run_led = nxt_blink;
    end
  end

  // registers
  always_ff @(posedge clock) begin
    if (srst) begin
      blink_cnt_ff <= 32'h0;
      blink_ff <= 1'b0;
      run_led_ff <= 1'b0;
    end else begin
      blink_cnt_ff <= nxt_blink_cnt;
      blink_ff <= nxt_blink;
      run_led_ff <= nxt_run_led;
    end
  end

  assign run_led = run_led_ff;
endmodule

/* rtl/fieldbus_master_state_control.sv */
// fieldbus master communication state controller with apb registers
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "fbm_consts.svh"
module fieldbus_master_state_control #(
  parameter int FLASH_HALF_CYCLES = `FBM_FLASH_HALF_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // diagnosis and fault pins
  input wire logic cfg_image_ok,
  input wire logic hw_addr_ok,
  input wire logic port_ctrl_ok,
  input wire logic link_fault,
  // outputs to the traffic engines and panel
  output fbm_pkg::traffic_gate_t traffic_gate,
  output fbm_pkg::diag_flags_t diag_flags,
  output logic [1:0] state_code,
  output logic run_led,
  output logic irq
);
  // pin synchronisers: stage one feeds stage two only
  logic [3:0] pin_meta_ff;
  logic [3:0] pin_sync_ff;
  // control state
  fbm_pkg::ctl_state_t state_ff;
  fbm_pkg::ctl_state_t nxt_state;
  logic [1:0] code_ff; // readable encoded state
  logic [1:0] nxt_code;
  fbm_pkg::traffic_gate_t gate_ff;
  fbm_pkg::traffic_gate_t nxt_gate;
  // diagnosis
  logic [3:0] diag_cnt_ff;
  logic [3:0] nxt_diag_cnt;
  logic diag_done_ff;
  logic nxt_diag_done;
  fbm_pkg::diag_flags_t flags_ff;
  fbm_pkg::diag_flags_t nxt_flags;
  logic diag_fire; // one-cycle pulse when diagnosis finishes
  // registers
  logic [`FBM_CTRL_WIDTH-1:0] ctrl_ff;
  logic [`FBM_CTRL_WIDTH-1:0] nxt_ctrl;
  logic [`FBM_IRQ_WIDTH-1:0] irq_status_ff;
  logic [`FBM_IRQ_WIDTH-1:0] nxt_irq_status;
  logic [`FBM_IRQ_WIDTH-1:0] irq_mask_ff;
  logic [`FBM_IRQ_WIDTH-1:0] nxt_irq_mask;
  logic [`FBM_IRQ_WIDTH-1:0] irq_event;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic irq_ff;
  logic nxt_irq;
  // bus decode, fault and fallback terms
  logic wr_en;
  logic addr_hit;
  logic any_err;
  logic link_bad;
  logic fallback;

  // two-flop synchroniser for every pin input
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_meta_ff <= 4'h0;
      pin_sync_ff <= 4'h0;
    end else begin
      pin_meta_ff <= {link_fault, port_ctrl_ok, hw_addr_ok, cfg_image_ok};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign link_bad = pin_sync_ff[3];
  assign any_err = |flags_ff;

  // power-on diagnosis: let the synchronisers settle, then sample once
  always_comb begin
    nxt_diag_cnt = diag_cnt_ff;
    nxt_diag_done = diag_done_ff;
    nxt_flags = flags_ff;
    diag_fire = 1'b0;
    if (!diag_done_ff) begin
      nxt_diag_cnt = diag_cnt_ff + 4'h1;
      if (diag_cnt_ff == `FBM_DIAG_CYCLES - 4'h1) begin
        diag_fire = 1'b1;
        nxt_diag_done = 1'b1;
        nxt_flags.net_config_error_flag = ~pin_sync_ff[0];
        nxt_flags.hw_address_error_flag = ~pin_sync_ff[1];
        nxt_flags.port_controller_fault_flag = ~pin_sync_ff[2];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      diag_cnt_ff <= 4'h0;
      diag_done_ff <= 1'b0;
      flags_ff <= '0;
    end else begin
      diag_cnt_ff <= nxt_diag_cnt;
      diag_done_ff <= nxt_diag_done;
      flags_ff <= nxt_flags;
    end
  end

  // control state machine; faults act without software help
  always_comb begin
    nxt_state = state_ff;
    fallback = 1'b0;
    case (state_ff)
      fbm_pkg::ST_INIT: begin
        // needs clean diagnosis and a loaded configuration
        if (diag_done_ff && !any_err && ctrl_ff[`FBM_CTRL_CFG_LOADED]) begin
          nxt_state = fbm_pkg::ST_PREOP;
        end
      end
      fbm_pkg::ST_PREOP: begin
        if (!ctrl_ff[`FBM_CTRL_CFG_LOADED]) begin
          nxt_state = fbm_pkg::ST_INIT;
          fallback = 1'b1;
        // held here while the link is bad, else preop and safeop would chase each other
        end else if (ctrl_ff[`FBM_CTRL_SETUP_DONE] && !link_bad) begin
          nxt_state = fbm_pkg::ST_SAFEOP;
        end
      end
      fbm_pkg::ST_SAFEOP: begin
        if (!ctrl_ff[`FBM_CTRL_CFG_LOADED]) begin
          nxt_state = fbm_pkg::ST_INIT;
          fallback = 1'b1;
        end else if (link_bad) begin
          nxt_state = fbm_pkg::ST_PREOP;
          fallback = 1'b1;
        end else if (ctrl_ff[`FBM_CTRL_GO_OP]) begin
          nxt_state = fbm_pkg::ST_OP;
        end
      end
      fbm_pkg::ST_OP: begin
        if (!ctrl_ff[`FBM_CTRL_CFG_LOADED]) begin
          nxt_state = fbm_pkg::ST_INIT;
          fallback = 1'b1;
        end else if (link_bad) begin
          nxt_state = fbm_pkg::ST_SAFEOP;
          fallback = 1'b1;
        end
      end
      default: begin
        nxt_state = fbm_pkg::ST_INIT;
      end
    endcase
    // encoded state and gates follow the next state so they switch together
    nxt_code = `FBM_CODE_INIT;
    nxt_gate = '0;
    case (nxt_state)
      fbm_pkg::ST_PREOP: begin
        nxt_code = `FBM_CODE_PREOP;
        nxt_gate.mailbox_en = 1'b1;
      end
      fbm_pkg::ST_SAFEOP: begin
        nxt_code = `FBM_CODE_SAFEOP;
        nxt_gate.mailbox_en = 1'b1;
        nxt_gate.pd_in_en = 1'b1;
      end
      fbm_pkg::ST_OP: begin
        nxt_code = `FBM_CODE_OP;
        nxt_gate = 3'h7;
      end
      default: begin
        nxt_code = `FBM_CODE_INIT;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= fbm_pkg::ST_INIT;
      code_ff <= `FBM_CODE_INIT;
      gate_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      code_ff <= nxt_code;
      gate_ff <= nxt_gate;
    end
  end

  // apb decode: zero-wait access, read data captured in the setup cycle
  assign addr_hit = (paddr == `FBM_OFS_CTRL) || (paddr == `FBM_OFS_STATE) ||
                    (paddr == `FBM_OFS_IRQ_STATUS) || (paddr == `FBM_OFS_IRQ_MASK);
  assign wr_en = psel && penable && pwrite && addr_hit;

  // interrupt sources, each a one-cycle event
  assign irq_event = {fallback, (nxt_state != state_ff),
                      diag_fire & ~pin_sync_ff[2], diag_fire & ~pin_sync_ff[1], diag_fire & ~pin_sync_ff[0]};

  // register file next values
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_irq_status = irq_status_ff;
    nxt_prdata = prdata_ff;
    if (wr_en) begin
      if (paddr == `FBM_OFS_CTRL) begin
        nxt_ctrl = pwdata[`FBM_CTRL_WIDTH-1:0];
      end else if (paddr == `FBM_OFS_IRQ_STATUS) begin
        nxt_irq_status = irq_status_ff & ~pwdata[`FBM_IRQ_WIDTH-1:0]; // write one to clear
      end else if (paddr == `FBM_OFS_IRQ_MASK) begin
        nxt_irq_mask = pwdata[`FBM_IRQ_WIDTH-1:0];
      end
    end
    // a new event wins over a clear in the same cycle
    nxt_irq_status = nxt_irq_status | irq_event;
    nxt_irq = |(nxt_irq_status & nxt_irq_mask);
    if (psel && !penable && !pwrite) begin
      nxt_prdata = 32'h0;
      if (paddr == `FBM_OFS_CTRL) begin
        nxt_prdata[`FBM_CTRL_WIDTH-1:0] = ctrl_ff;
      end else if (paddr == `FBM_OFS_STATE) begin
        nxt_prdata[`FBM_STATE_CODE_LSB +: 2] = code_ff;
        nxt_prdata[`FBM_STATE_FLAGS_LSB +: 3] = flags_ff;
        nxt_prdata[`FBM_STATE_DIAG_DONE] = diag_done_ff;
      end else if (paddr == `FBM_OFS_IRQ_STATUS) begin
        nxt_prdata[`FBM_IRQ_WIDTH-1:0] = irq_status_ff;
      end else if (paddr == `FBM_OFS_IRQ_MASK) begin
        nxt_prdata[`FBM_IRQ_WIDTH-1:0] = irq_mask_ff;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_ff <= `FBM_CTRL_RESET;
      irq_status_ff <= `FBM_IRQ_RESET;
      irq_mask_ff <= `FBM_IRQ_RESET;
      prdata_ff <= 32'h0;
      irq_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      irq_status_ff <= nxt_irq_status;
      irq_mask_ff <= nxt_irq_mask;
      prdata_ff <= nxt_prdata;
      irq_ff <= nxt_irq;
    end
  end

  // lamp driver
  run_indicator #(
    .HALF_CYCLES(FLASH_HALF_CYCLES)
  ) u_run_indicator (
    .clock(clock),
    .srst(srst),
    .state_code(code_ff),
    .run_led(run_led)
  );

  // outputs
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign traffic_gate = gate_ff;
  assign diag_flags = flags_ff;
  assign state_code = code_ff;
  assign irq = irq_ff;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_in_safeop;
    code_ff == `FBM_CODE_SAFEOP;
  endsequence
  sequence s_enter_op;
    code_ff == `FBM_CODE_OP && $past(code_ff) != `FBM_CODE_OP;
  endsequence

  a_op_entry_path: assert property (s_enter_op |-> $past(code_ff) == `FBM_CODE_SAFEOP)
    else $error("operational entered from a state other than safe-operational");
  a_init_no_traffic: assert property (code_ff == `FBM_CODE_INIT |-> gate_ff == 3'h0)
    else $error("traffic allowed in init");
  a_preop_mbx_only: assert property (code_ff == `FBM_CODE_PREOP |-> gate_ff == 3'h1)
    else $error("pre-operational gate pattern wrong");
  a_safeop_inputs_only: assert property (s_in_safeop |-> gate_ff == 3'h3)
    else $error("safe-operational gate pattern wrong");
  a_op_all_open: assert property (code_ff == `FBM_CODE_OP |-> gate_ff == 3'h7)
    else $error("operational gate pattern wrong");
  a_stay_init_nocfg: assert property (!ctrl_ff[`FBM_CTRL_CFG_LOADED] |=> code_ff == `FBM_CODE_INIT)
    else $error("left init without configuration");
  a_preop_from_init: assert property
    (code_ff == `FBM_CODE_PREOP && $past(code_ff) == `FBM_CODE_INIT |-> $past(diag_done_ff) && !$past(any_err))
    else $error("pre-operational entered before clean diagnosis");
  a_link_fault_drop: assert property
    (code_ff == `FBM_CODE_OP && link_bad && ctrl_ff[`FBM_CTRL_CFG_LOADED] |=> code_ff == `FBM_CODE_SAFEOP)
    else $error("no automatic fallback on link fault");
  a_cfg_flag_set: assert property (diag_fire |=> flags_ff.net_config_error_flag == $past(~pin_sync_ff[0]))
    else $error("configuration error flag not set from check");
  a_port_flags_set: assert property
    (diag_fire |=> flags_ff[2:1] == $past(~pin_sync_ff[2:1]))
    else $error("port diagnosis flags wrong");
  a_lamp_steady_op: assert property ((code_ff == `FBM_CODE_OP) [*2] |-> run_led)
    else $error("lamp not steady in operational");
  a_diag_done_time: assert property ($rose(diag_done_ff) |-> $past(diag_cnt_ff) == `FBM_DIAG_CYCLES - 4'h1)
    else $error("diagnosis finished at wrong count");
endmodule

/* tb/slave_chain_model.sv */
// behavioural far side: slave chain health and link condition seen as pins
`timescale 1ns/1ps
module slave_chain_model (
  // clock
  input wire logic clock,
  // bench commands
  input wire logic cfg_good,
  input wire logic addr_good,
  input wire logic ctrl_good,
  input wire logic break_link,
  // pins toward the master
  output logic cfg_image_ok,
  output logic hw_addr_ok,
  output logic port_ctrl_ok,
  output logic link_fault
);
  // pins move only just after an edge, never mid-cycle
  always_ff @(posedge clock) begin
    cfg_image_ok <= cfg_good;
    hw_addr_ok <= addr_good;
    port_ctrl_ok <= ctrl_good;
    // a slave dropping out forces the chain back down the states
    link_fault <= break_link;
  end
endmodule

/* tb/fieldbus_master_state_control_tb.sv */
// self-checking bench for the fieldbus master state control
`timescale 1ns/1ps
`include "fbm_consts.svh"
module fieldbus_master_state_control_tb;
  // one row: control word, expected code, gates, lamp (0 dark, 1 flash, 2 lit)
  typedef struct packed {logic [2:0] ctrl; logic [1:0] code; logic [2:0] gate; logic [1:0] lamp;} row_t;
  localparam row_t rows [5] = '{
    '{3'h0, 2'h0, 3'h0, 2'h0},
    '{3'h1, 2'h1, 3'h1, 2'h1},
    '{3'h5, 2'h1, 3'h1, 2'h1},
    '{3'h3, 2'h2, 3'h3, 2'h1},
    '{3'h7, 2'h3, 3'h7, 2'h2}};
  // stimulus, all valued at time zero
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic cfg_good = 1'b1;
  logic addr_good = 1'b1;
  logic ctrl_good = 1'b1;
  logic break_link = 1'b0;
  // design outputs and pins
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cfg_image_ok;
  logic hw_addr_ok;
  logic port_ctrl_ok;
  logic link_fault;
  fbm_pkg::traffic_gate_t traffic_gate;
  fbm_pkg::diag_flags_t diag_flags;
  logic [1:0] state_code;
  logic run_led;
  logic irq;
  // captured answer of the last transfer
  logic [31:0] rdata;
  logic err;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  // 100 MHz clock
  always #5 clock = ~clock;

  // short flash period keeps the run brief
  fieldbus_master_state_control #(.FLASH_HALF_CYCLES(4)) u_fieldbus_master_state_control (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg_image_ok(cfg_image_ok),
    .hw_addr_ok(hw_addr_ok), .port_ctrl_ok(port_ctrl_ok), .link_fault(link_fault),
    .traffic_gate(traffic_gate), .diag_flags(diag_flags), .state_code(state_code), .run_led(run_led), .irq(irq));

  slave_chain_model u_slave_chain_model (
    .clock(clock), .cfg_good(cfg_good), .addr_good(addr_good), .ctrl_good(ctrl_good),
    .break_link(break_link), .cfg_image_ok(cfg_image_ok), .hw_addr_ok(hw_addr_ok),
    .port_ctrl_ok(port_ctrl_ok), .link_fault(link_fault));

  // verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // value compare, four-state exact
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at an edge, only the hang guard ends a wait
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // lamp over one flash half period: flashing must toggle, else hold
  task automatic check_lamp(input logic [1:0] kind);
    logic first;
    first = run_led;
    repeat (4) @(posedge clock);
    if (kind == 2'h1)
      check({31'h0, run_led}, {31'h0, ~first});
    else
      check({30'h0, first, run_led}, (kind == 2'h2) ? 32'h3 : 32'h0);
  endtask

  // hang guard, run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    repeat (12) @(posedge clock);
    check({30'h0, state_code}, 32'h0);
    apb(1'b0, `FBM_OFS_STATE, 32'h0);
    // the application reads diagnosis and state before it relies on any slave data
    check(rdata, 32'h20);
    apb(1'b1, `FBM_OFS_IRQ_MASK, 32'h08);
    // climb the states row by row
    foreach (rows[i]) begin
      apb(1'b1, `FBM_OFS_CTRL, {29'h0, rows[i].ctrl});
      repeat (4) @(posedge clock);
      check({30'h0, state_code}, {30'h0, rows[i].code});
      check({29'h0, traffic_gate}, {29'h0, rows[i].gate});
      check_lamp(rows[i].lamp);
      apb(1'b0, `FBM_OFS_STATE, 32'h0);
      check(rdata, {26'h0, 1'b1, 3'h0, rows[i].code});
    end
    // state change interrupt raised, then cleared by write one
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `FBM_OFS_IRQ_STATUS, 32'h1f);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h0);
    apb(1'b0, `FBM_OFS_IRQ_STATUS, 32'h0);
    check(rdata, 32'h0);
    // unmapped place refused, read-only state ignores writes
    apb(1'b1, 8'h10, 32'hffff_ffff);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check(rdata, 32'h0);
    apb(1'b1, `FBM_OFS_STATE, 32'h0);
    check({30'h0, state_code}, 32'h3);
    // link fault: automatic fall back without software, then climb again
    apb(1'b1, `FBM_OFS_IRQ_MASK, 32'h10);
    break_link <= 1'b1;
    repeat (10) @(posedge clock);
    check({30'h0, state_code}, 32'h1);
    check({31'h0, irq}, 32'h1);
    break_link <= 1'b0;
    repeat (10) @(posedge clock);
    check({30'h0, state_code}, 32'h3);
    apb(1'b1, `FBM_OFS_CTRL, 32'h0);
    repeat (3) @(posedge clock);
    check({30'h0, state_code}, 32'h0);
    // second reset with faulty configuration and hardware address
    cfg_good <= 1'b0;
    addr_good <= 1'b0;
    srst <= 1'b1;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    repeat (12) @(posedge clock);
    check({29'h0, diag_flags}, 32'h3);
    apb(1'b0, `FBM_OFS_STATE, 32'h0);
    check(rdata, 32'h2c);
    apb(1'b1, `FBM_OFS_CTRL, 32'h7);
    repeat (6) @(posedge clock);
    check({30'h0, state_code}, 32'h0);
    check_lamp(2'h0);
    apb(1'b0, `FBM_OFS_IRQ_STATUS, 32'h0);
    check({29'h0, rdata[2:0]}, 32'h3);
    // third reset: port controller fault alone
    cfg_good <= 1'b1;
    addr_good <= 1'b1;
    ctrl_good <= 1'b0;
    srst <= 1'b1;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    repeat (12) @(posedge clock);
    check({29'h0, diag_flags}, 32'h4);
    apb(1'b0, `FBM_OFS_STATE, 32'h0);
    check(rdata, 32'h30);
    finish_test();
  end
endmodule
